// ==== core/rsp_dev.sv ====
// Purpose: Radio end of the serial register port
// Assumes: Host drives sck low while idle, mode 0
// Notes:   Frame logic resets while slave select is high
//
// Contract
// R1: Command bit 7 high writes, low reads
// R2: Bit 6 set advances address per byte
// R3: Low six command bits pick a register
// R4: Command byte then eight-bit data bytes
// R5: Host clocks; data in on MOSI, out MISO
// R6: Host asserts select low before any transfer
// R7: Burst of any length, ends at select high
// R8: Three-pin mode drives shared pin only reading
// R9: Host releases shared pin unless sending
// R10: FIFO address pushes or pops per byte
// R11: Muxed interrupt shows only while select high
// R12: Host releases MOSI while select is high
// R13: Port runs purely from serial clock
// R14: MSB first, sample rising, change falling
// R15: Four-pin output released while select high
`timescale 1ns/1ps
`default_nettype none
module rsp_dev (
  rsp_if.dev                          bus,
  input  wire logic                   clk_sys,
  input  wire logic                   arst_n,
  input  wire logic                   irq_in,
  output logic [rsp_pkg::DATA_W-1:0]  core_cfg
);
  import rsp_pkg::*;

  logic [DATA_W-1:0]  regs [2**ADDR_W];
  logic [DATA_W-1:0]  fifo [FIFO_DEPTH];
  logic [DATA_W-1:0]  cfg_reg;
  logic [FPTR_W-1:0]  wr_ptr_reg;
  logic [FPTR_W-1:0]  rd_ptr_reg;
  logic [FCNT_W-1:0]  cnt_reg;
  rsp_dphase_type     phase_reg;
  logic [2:0]         bit_reg;
  logic [DATA_W-1:0]  shift_reg;
  logic [DATA_W-1:0]  tx_reg;
  logic [ADDR_W-1:0]  addr_reg;
  logic               inc_reg;
  logic               dout_reg;
  logic               doe_reg;
  logic               frame_rst_n;
  logic [DATA_W-1:0]  byte_in;
  logic               byte_done;
  logic               wr_done;
  logic               rd_done;
  logic               push;
  logic               pop;
  logic [ADDR_W-1:0]  next_addr;
  logic [FPTR_W-1:0]  next_rd_ptr;
  logic [1:0]         irq_sync_reg;
  logic [1:0]         ss_sync_reg;
  logic [DATA_W-1:0]  cfg_s1_reg;
  logic [DATA_W-1:0]  cfg_s2_reg;
  logic               irq_do_reg;
  logic               irq_oe_reg;
  logic               irq_pin_reg;
  logic               irq_oe_rst_n;

  // Read value of a register, FIFO head or port status
  function automatic logic [DATA_W-1:0] rd_val(
    input logic [ADDR_W-1:0] a,
    input logic [FPTR_W-1:0] p
  );
    logic [DATA_W-1:0] v;
    v = regs[a];
    if (a == REG_CFG)
      v = cfg_reg;
    else if (a == REG_FIFO)
      v = fifo[p];
    else if (a == REG_STAT)
      v = DATA_W'(cnt_reg);
    return v;
  endfunction

  // Select high clears the frame, so stray clocks between frames are ignored
  assign frame_rst_n = arst_n & ~bus.ss_n; // R6 R7
  assign byte_in     = {shift_reg[DATA_W-2:0], bus.dev_di}; // R5 R14
  assign byte_done   = (bit_reg == LAST_BIT); // R4
  assign wr_done     = byte_done && (phase_reg == DP_WR);
  assign rd_done     = byte_done && (phase_reg == DP_RD);
  assign push        = wr_done && (addr_reg == REG_FIFO) &&
                       (cnt_reg != FCNT_FULL); // R10
  assign pop         = rd_done && (addr_reg == REG_FIFO) &&
                       (cnt_reg != '0); // R10
  assign next_addr   = inc_reg ? addr_reg + ADDR_ONE : addr_reg; // R2
  assign next_rd_ptr = pop ? rd_ptr_reg + FPTR_ONE : rd_ptr_reg;

  // Everything below up to the irq logic runs on sck alone, so sleep
  // with the core oscillator stopped does not block register access
  always_ff @(posedge bus.sck or negedge frame_rst_n) // R13
  begin
    if (!frame_rst_n)
    begin
      phase_reg <= DP_CMD;
      bit_reg   <= '0;
      shift_reg <= '0;
      tx_reg    <= '0;
      addr_reg  <= '0;
      inc_reg   <= 1'b0;
    end
    else
    begin
      bit_reg   <= bit_reg + BIT_ONE;
      shift_reg <= byte_in; // R14
      if (byte_done)
      begin
        case (phase_reg)
          DP_CMD:
          begin
            phase_reg <= byte_in[DIR_BIT] ? DP_WR : DP_RD; // R1
            inc_reg   <= byte_in[INC_BIT]; // R2
            addr_reg  <= byte_in[ADDR_W-1:0]; // R3
            tx_reg    <= rd_val(byte_in[ADDR_W-1:0], rd_ptr_reg);
          end
          DP_WR:
            addr_reg <= next_addr; // R2 R7
          DP_RD:
          begin
            addr_reg <= next_addr; // R2 R7
            tx_reg   <= rd_val(next_addr, next_rd_ptr);
          end
          default:
            phase_reg <= DP_CMD;
        endcase
      end
    end
  end

  // Register file and FIFO keep their contents across frames
  always_ff @(posedge bus.sck or negedge arst_n)
  begin
    if (!arst_n)
    begin
      cfg_reg <= CFG_RST;
      for (int i = 0; i < 2**ADDR_W; i++)
        regs[i] <= '0;
    end
    else if (wr_done && frame_rst_n)
    begin
      if (addr_reg == REG_CFG)
        cfg_reg <= byte_in; // R3
      else if (addr_reg != REG_FIFO && addr_reg != REG_STAT)
        regs[addr_reg] <= byte_in; // R3
    end
  end

  // FIFO storage needs no reset; the pointers define what is valid
  always_ff @(posedge bus.sck)
  begin
    if (push && frame_rst_n)
      fifo[wr_ptr_reg] <= byte_in; // R10
  end

  // A full FIFO drops further write bytes silently
  always_ff @(posedge bus.sck or negedge arst_n)
  begin
    if (!arst_n)
    begin
      wr_ptr_reg <= '0;
      rd_ptr_reg <= '0;
      cnt_reg    <= '0;
    end
    else if (frame_rst_n)
    begin
      if (push)
        wr_ptr_reg <= wr_ptr_reg + FPTR_ONE; // R10
      rd_ptr_reg <= next_rd_ptr; // R10
      case ({push, pop})
        2'h2:    cnt_reg <= cnt_reg + FCNT_ONE;
        2'h1:    cnt_reg <= cnt_reg - FCNT_ONE;
        default: cnt_reg <= cnt_reg;
      endcase
    end
  end

  // Output changes on the falling edge so the host samples it stable
  always_ff @(negedge bus.sck or negedge frame_rst_n)
  begin
    if (!frame_rst_n)
    begin
      dout_reg <= 1'b0;
      doe_reg  <= 1'b0; // R15
    end
    else
    begin
      dout_reg <= tx_reg[LAST_BIT - bit_reg]; // R5 R14
      doe_reg  <= (phase_reg == DP_RD); // R8
    end
  end

  assign bus.dev_do    = dout_reg;
  assign bus.dev_oe    = doe_reg;
  assign bus.three_pin = cfg_reg[CFG_3PIN]; // R8

  // Interrupt side on the core clock; it must run while sck stands still
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      irq_sync_reg <= '0;
      ss_sync_reg  <= 2'h3;
      cfg_s1_reg   <= CFG_RST;
      cfg_s2_reg   <= CFG_RST;
    end
    else
    begin
      irq_sync_reg <= {irq_sync_reg[0], irq_in};
      ss_sync_reg  <= {ss_sync_reg[0], bus.ss_n};
      cfg_s1_reg   <= cfg_reg;
      cfg_s2_reg   <= cfg_s1_reg;
    end
  end

  // Config bits are quasi-static, so per-bit level sync is enough
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      irq_do_reg  <= 1'b0;
      irq_pin_reg <= 1'b0;
    end
    else
    begin
      irq_do_reg  <= irq_sync_reg[1];
      irq_pin_reg <= irq_sync_reg[1] && !cfg_s2_reg[CFG_IRQMUX];
    end
  end

  // Select low drops the muxed interrupt at once, so the host never
  // fights it; release waits for the synced select
  assign irq_oe_rst_n = arst_n & bus.ss_n; // R11

  always_ff @(posedge clk_sys or negedge irq_oe_rst_n)
  begin
    if (!irq_oe_rst_n)
      irq_oe_reg <= 1'b0;
    else
      irq_oe_reg <= cfg_s2_reg[CFG_IRQMUX] && ss_sync_reg[1]; // R11
  end

  assign bus.irq_do  = irq_do_reg;
  assign bus.irq_oe  = irq_oe_reg;
  assign bus.irq_pin = irq_pin_reg;
  assign core_cfg    = cfg_s2_reg;
endmodule
`default_nettype wire

// ==== core/rsp_host.sv ====
// Purpose: Serial host that drives the radio port from a register port
// Assumes: Mode settings match the radio's own config register
// Notes:   One data write per byte; reads clock a dummy byte
//
// Added by the designer: the address-and-strobe port and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
module rsp_host (
  rsp_if.host                         bus,
  input  wire logic                   clk_sys,
  input  wire logic                   arst_n,
  input  wire logic [7:0]             reg_addr,
  input  wire logic [7:0]             reg_wdata,
  input  wire logic                   reg_we,
  input  wire logic                   reg_re,
  output logic [7:0]                  reg_rdata
);
  import rsp_pkg::*;

  rsp_hstate_type     st_reg;
  logic [HCNT_W-1:0]  cnt_reg;
  logic [2:0]         bit_reg;
  logic [DATA_W-1:0]  tx_reg;
  logic [DATA_W-1:0]  rx_reg;
  logic [DATA_W-1:0]  rxd_reg;
  logic [DATA_W-1:0]  data_reg;
  logic [DATA_W-1:0]  cfg_reg;
  logic [7:0]         rdata_reg;
  logic               is_cmd_reg;
  logic               dir_wr_reg;
  logic               pend_reg;
  logic               end_reg;
  logic               rxv_reg;
  logic               sck_reg;
  logic               ss_n_reg;
  logic               do_reg;
  logic               oe_reg;
  logic [1:0]         di_sync_reg;
  logic [1:0]         mosi_sync_reg;
  logic [1:0]         irqp_sync_reg;
  logic               half_done;
  logic               byte_done;
  logic               take_data;
  logic               take_end;
  logic               irq_seen;
  logic               three;

  assign three     = cfg_reg[CFG_3PIN];
  assign half_done = (cnt_reg == SCK_HALF_CYC - HCNT_ONE);
  assign byte_done = (st_reg == HST_HIGH) && half_done &&
                     (bit_reg == LAST_BIT);
  assign take_data = (st_reg == HST_WAIT) && pend_reg;
  assign take_end  = (st_reg == HST_WAIT) && !pend_reg && end_reg;
  assign irq_seen  = cfg_reg[CFG_IRQMUX] ?
                     (ss_n_reg && mosi_sync_reg[1]) : irqp_sync_reg[1];

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      di_sync_reg   <= '0;
      mosi_sync_reg <= '0;
      irqp_sync_reg <= '0;
    end
    else
    begin
      di_sync_reg   <= {di_sync_reg[0], bus.host_di};
      mosi_sync_reg <= {mosi_sync_reg[0], bus.mosi_w};
      irqp_sync_reg <= {irqp_sync_reg[0], bus.irq_pin};
    end
  end

  // Serial engine; sck comes from a divider of clk_sys
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      st_reg     <= HST_IDLE;
      cnt_reg    <= '0;
      bit_reg    <= '0;
      tx_reg     <= '0;
      rx_reg     <= '0;
      is_cmd_reg <= 1'b0;
      dir_wr_reg <= 1'b0;
      sck_reg    <= 1'b0;
      ss_n_reg   <= 1'b1;
      do_reg     <= 1'b0;
      oe_reg     <= 1'b0;
    end
    else
    begin
      case (st_reg)
        HST_IDLE:
          if (reg_we && reg_addr == HR_CMD)
          begin
            tx_reg     <= reg_wdata;
            dir_wr_reg <= reg_wdata[DIR_BIT]; // R1
            is_cmd_reg <= 1'b1;
            ss_n_reg   <= 1'b0; // R6
            do_reg     <= reg_wdata[MSB_BIT]; // R14
            oe_reg     <= 1'b1; // R4
            cnt_reg    <= '0;
            bit_reg    <= '0;
            st_reg     <= HST_LOW;
          end
        HST_LOW:
          if (half_done)
          begin
            cnt_reg <= '0;
            sck_reg <= 1'b1; // R5
            st_reg  <= HST_HIGH;
          end
          else
            cnt_reg <= cnt_reg + HCNT_ONE;
        HST_HIGH:
          if (half_done)
          begin
            cnt_reg <= '0;
            sck_reg <= 1'b0;
            // Sampled late in the high half, past the sync delay
            rx_reg  <= {rx_reg[DATA_W-2:0], di_sync_reg[1]}; // R14
            if (bit_reg == LAST_BIT)
            begin
              st_reg <= HST_WAIT;
              if (three)
                oe_reg <= 1'b0; // R9
            end
            else
            begin
              bit_reg <= bit_reg + BIT_ONE;
              tx_reg  <= {tx_reg[DATA_W-2:0], 1'b0};
              do_reg  <= tx_reg[MSB_BIT-1]; // R14
              st_reg  <= HST_LOW;
            end
          end
          else
            cnt_reg <= cnt_reg + HCNT_ONE;
        HST_WAIT:
          if (take_data)
          begin
            tx_reg     <= data_reg; // R7
            do_reg     <= data_reg[MSB_BIT];
            oe_reg     <= !three || dir_wr_reg; // R9
            is_cmd_reg <= 1'b0;
            bit_reg    <= '0;
            cnt_reg    <= '0;
            st_reg     <= HST_LOW;
          end
          else if (take_end)
          begin
            cnt_reg <= '0;
            st_reg  <= HST_END;
          end
        HST_END:
          if (half_done)
          begin
            ss_n_reg <= 1'b1; // R7
            oe_reg   <= 1'b0; // R12
            st_reg   <= HST_IDLE;
          end
          else
            cnt_reg <= cnt_reg + HCNT_ONE;
        default:
          st_reg <= HST_IDLE;
      endcase
    end
  end

  // Software sets pending flags; hardware consumption loses to a new set
  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
    begin
      data_reg <= '0;
      cfg_reg  <= CFG_RST;
      pend_reg <= 1'b0;
      end_reg  <= 1'b0;
      rxv_reg  <= 1'b0;
      rxd_reg  <= '0;
    end
    else
    begin
      if (reg_we && reg_addr == HR_DATA)
        data_reg <= reg_wdata;
      if (reg_we && reg_addr == HR_CFG)
        cfg_reg <= reg_wdata;
      pend_reg <= (reg_we && reg_addr == HR_DATA) ||
                  (pend_reg && !take_data);
      end_reg  <= (reg_we && reg_addr == HR_END) ||
                  (end_reg && !take_end);
      if (byte_done && !is_cmd_reg && !dir_wr_reg)
        rxd_reg <= {rx_reg[DATA_W-2:0], di_sync_reg[1]};
      rxv_reg  <= (byte_done && !is_cmd_reg && !dir_wr_reg) ||
                  (rxv_reg && !(reg_re && reg_addr == HR_DATA));
    end
  end

  always_ff @(posedge clk_sys or negedge arst_n)
  begin
    if (!arst_n)
      rdata_reg <= '0;
    else if (reg_re)
    begin
      case (reg_addr)
        HR_DATA: rdata_reg <= rxd_reg;
        HR_CFG:  rdata_reg <= cfg_reg;
        HR_STAT:
        begin
          rdata_reg          <= '0;
          rdata_reg[HS_BUSY] <= (st_reg != HST_IDLE);
          rdata_reg[HS_PEND] <= pend_reg;
          rdata_reg[HS_RXV]  <= rxv_reg;
          rdata_reg[HS_IRQ]  <= irq_seen;
          rdata_reg[HS_WAIT] <= (st_reg == HST_WAIT);
        end
        default: rdata_reg <= '0;
      endcase
    end
    else
      rdata_reg <= '0;
  end

  assign bus.sck     = sck_reg;
  assign bus.ss_n    = ss_n_reg;
  assign bus.host_do = do_reg;
  assign bus.host_oe = oe_reg;
  assign reg_rdata   = rdata_reg;
endmodule
`default_nettype wire

// ==== core/rsp_if.sv ====
// Purpose: Board wiring between the serial host and the radio port
// Assumes: Undriven lines float high through a pull-up
// Notes:   Works out the shared line levels from the enables
`timescale 1ns/1ps
`default_nettype none
interface rsp_if;
  logic sck;
  logic ss_n;
  logic host_do;
  logic host_oe;
  logic dev_do;
  logic dev_oe;
  logic irq_do;
  logic irq_oe;
  logic irq_pin;
  logic three_pin;
  logic mosi_w;
  logic miso_w;
  logic bidir_serial_data;
  logic dev_di;
  logic host_di;

  assign mosi_w  = host_oe ? host_do : (irq_oe ? irq_do : 1'b1);
  assign miso_w  = dev_oe ? dev_do : 1'b1;
  assign bidir_serial_data = host_oe ? host_do :
                             (dev_oe ? dev_do : (irq_oe ? irq_do : 1'b1));
  assign dev_di  = three_pin ? bidir_serial_data : mosi_w;
  assign host_di = three_pin ? bidir_serial_data : miso_w;

  modport dev (
    input  sck, ss_n, dev_di,
    output dev_do, dev_oe, irq_do, irq_oe, irq_pin, three_pin
  );
  modport host (
    output sck, ss_n, host_do, host_oe,
    input  host_di, mosi_w, irq_pin
  );
endinterface
`default_nettype wire

// ==== core/rsp_pkg.sv ====
// Purpose: Shared constants and types for the radio serial register port
// Assumes: Mode 0 framing, 8-bit bytes, 6-bit register address
// Notes:   Host offsets are byte addresses on the host's command port
package rsp_pkg;
  localparam int DATA_W    = 8;
  localparam int ADDR_W    = 6;
  localparam int DIR_BIT   = 7;
  localparam int INC_BIT   = 6;
  localparam int MSB_BIT   = 7;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [2:0] BIT_ONE  = 3'h1;
  localparam logic [ADDR_W-1:0] ADDR_ONE = 6'h01;

  localparam logic [ADDR_W-1:0] REG_CFG  = 6'h00;
  localparam logic [ADDR_W-1:0] REG_STAT = 6'h01;
  localparam logic [ADDR_W-1:0] REG_FIFO = 6'h20;
  localparam int CFG_3PIN   = 0;
  localparam int CFG_IRQMUX = 1;
  localparam logic [7:0] CFG_RST = 8'h00;

  localparam int FIFO_DEPTH = 16;
  localparam int FPTR_W     = 4;
  localparam int FCNT_W     = 5;
  localparam logic [FPTR_W-1:0] FPTR_ONE = 4'h1;
  localparam logic [FCNT_W-1:0] FCNT_ONE = 5'h01;
  localparam logic [FCNT_W-1:0] FCNT_FULL = 5'h10;

  localparam int CLK_SYS_NS  = 20;
  localparam int SCK_HALF_NS = 125;
  localparam int HCNT_W      = 4;
  localparam logic [HCNT_W-1:0] SCK_HALF_CYC =
    HCNT_W'((SCK_HALF_NS + CLK_SYS_NS - 1) / CLK_SYS_NS);
  localparam logic [HCNT_W-1:0] HCNT_ONE = 4'h1;

  localparam logic [7:0] HR_CMD  = 8'h00;
  localparam logic [7:0] HR_DATA = 8'h04;
  localparam logic [7:0] HR_END  = 8'h08;
  localparam logic [7:0] HR_STAT = 8'h0c;
  localparam logic [7:0] HR_CFG  = 8'h10;
  localparam int HS_BUSY = 0;
  localparam int HS_PEND = 1;
  localparam int HS_RXV  = 2;
  localparam int HS_IRQ  = 3;
  localparam int HS_WAIT = 4;

  typedef enum logic [1:0] {
    DP_CMD = 2'h0,
    DP_WR  = 2'h1,
    DP_RD  = 2'h3
  } rsp_dphase_type;

  typedef enum logic [2:0] {
    HST_IDLE = 3'h0,
    HST_LOW  = 3'h1,
    HST_HIGH = 3'h3,
    HST_WAIT = 3'h2,
    HST_END  = 3'h6
  } rsp_hstate_type;
endpackage

// ==== tb/rsp_checker.sv ====
// Purpose: Concurrent checks on the link between serial host and radio
// Assumes: Host builds sck from clk_sys, so link edges meet clk_sys edges
// Notes:   A small sck-side tracker counts rising edges within a frame
`timescale 1ns/1ps
`default_nettype none
module rsp_checker (
  input wire logic clk_sys,
  input wire logic arst_n,
  input wire logic sck,
  input wire logic ss_n,
  input wire logic host_do,
  input wire logic host_oe,
  input wire logic dev_do,
  input wire logic dev_oe,
  input wire logic irq_oe,
  input wire logic irq_pin,
  input wire logic three_pin
);
  logic [3:0] rise_cnt;
  logic       dir_bit;

  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!arst_n);

  // Cleared by deselect, so a partial frame never leaks into the next one
  always_ff @(posedge sck or posedge ss_n)
  begin
    if (ss_n)
      rise_cnt <= 4'h0;
    else if (rise_cnt != 4'hf)
      rise_cnt <= rise_cnt + 4'h1;
  end

  always_ff @(posedge sck or posedge ss_n)
  begin
    if (ss_n)
      dir_bit <= 1'b0;
    else if (rise_cnt == 4'h0)
      dir_bit <= host_do;
  end

  sequence read_cmd_done;
    !dir_bit && rise_cnt == 4'h8 && !sck;
  endsequence

  // A select held low for a while must keep the interrupt off the line
  sequence frame_settled;
    !ss_n [*5];
  endsequence

  dev_release_a: assert property (ss_n |-> !dev_oe)
    else $error("device drives data while deselected");
  read_turn_a: assert property ($rose(dev_oe) |-> read_cmd_done)
    else $error("read data turn not after eighth edge of a read");
  write_quiet_a: assert property (!ss_n && dir_bit |-> !dev_oe)
    else $error("device drives data during a write frame");
  dev_hold_a: assert property (sck && $past(sck) |-> $stable(dev_do))
    else $error("device data moved while sck high");
  host_hold_a: assert property (sck && $past(sck) |-> $stable(host_do))
    else $error("host data moved while sck high");
  idle_link_a: assert property (ss_n |-> !sck && !host_oe)
    else $error("clock or host data active while deselected");
  select_lead_a: assert property ($rose(sck) |-> !ss_n && !$past(ss_n))
    else $error("sck rose without select held low");
  shared_pin_a: assert property (three_pin && dev_oe |-> !host_oe)
    else $error("both ends drive the shared pin");
  irq_gap_a: assert property (frame_settled |-> !irq_oe)
    else $error("muxed interrupt driven while selected");
  irq_drop_a: assert property (!ss_n |-> !irq_oe)
    else $error("muxed interrupt not dropped at select");
  irq_route_a: assert property (irq_oe |-> !irq_pin)
    else $error("interrupt on both routes at once");
endmodule
`default_nettype wire

// ==== tb/test_radio_spi_register_port.sv ====
// Purpose: Self-checking bench for both ends of the radio serial port
// Assumes: Host offsets and device map as set in rsp_pkg
// Notes:   Device core clock is gated off in one test
`timescale 1ns/1ps
`default_nettype none
module test_radio_spi_register_port;
  import rsp_pkg::*;
  logic       clk_sys;
  logic       arst_n;
  logic       dev_clk_on;
  wire logic  dev_clk;
  logic       irq_in;
  logic [7:0] core_cfg;
  logic [7:0] reg_addr;
  logic [7:0] reg_wdata;
  logic       reg_we;
  logic       reg_re;
  logic [7:0] reg_rdata;
  logic [7:0] tx [0:16];
  logic [7:0] rx [0:16];
  logic [7:0] cmd_sh;
  logic [7:0] mv;
  logic [7:0] rv;
  int         bit_n;
  int         err_count;
  int         compares;

  rsp_if i_rsp_if ();
  assign dev_clk = clk_sys & dev_clk_on;
  rsp_dev i_rsp_dev (.bus(i_rsp_if), .clk_sys(dev_clk), .arst_n(arst_n),
    .irq_in(irq_in), .core_cfg(core_cfg));
  rsp_host i_rsp_host (.bus(i_rsp_if), .clk_sys(clk_sys), .arst_n(arst_n),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_we(reg_we),
    .reg_re(reg_re), .reg_rdata(reg_rdata));
  rsp_checker i_rsp_checker (.clk_sys(clk_sys), .arst_n(arst_n),
    .sck(i_rsp_if.sck), .ss_n(i_rsp_if.ss_n), .host_do(i_rsp_if.host_do),
    .host_oe(i_rsp_if.host_oe), .dev_do(i_rsp_if.dev_do),
    .dev_oe(i_rsp_if.dev_oe), .irq_oe(i_rsp_if.irq_oe),
    .irq_pin(i_rsp_if.irq_pin), .three_pin(i_rsp_if.three_pin));

  always #10 clk_sys = ~clk_sys;

  // First byte of each frame as the device input line carries it
  always @(posedge i_rsp_if.sck or posedge i_rsp_if.ss_n)
  begin
    if (i_rsp_if.ss_n)
      bit_n = 0;
    else
    begin
      if (bit_n < 8)
        cmd_sh = {cmd_sh[6:0], i_rsp_if.dev_di};
      bit_n = bit_n + 1;
    end
  end

  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
  begin
    compares = compares + 1;
    if (got !== exp)
    begin
      err_count = err_count + 1;
      $display("BAD t=%0t got %h expected %h", $time, got, exp);
    end
  end
  endtask

  task automatic reg_wr(input logic [7:0] a, input logic [7:0] d);
  begin
    @(posedge clk_sys);
    reg_addr  <= a;
    reg_wdata <= d;
    reg_we    <= 1'b1;
    @(posedge clk_sys);
    reg_we    <= 1'b0;
  end
  endtask

  task automatic reg_rd(input logic [7:0] a, output logic [7:0] d);
  begin
    @(posedge clk_sys);
    reg_addr <= a;
    reg_re   <= 1'b1;
    @(posedge clk_sys);
    reg_re   <= 1'b0;
    #1;
    d = reg_rdata;
  end
  endtask

  // Bounded poll of one status bit
  task automatic wait_bit(input int b, input logic v);
    int         n;
    logic [7:0] st;
  begin
    n = 0;
    reg_rd(HR_STAT, st);
    while (st[b] !== v && n < 400)
    begin
      reg_rd(HR_STAT, st);
      n = n + 1;
    end
    if (st[b] !== v)
    begin
      err_count = err_count + 1;
      $display("BAD t=%0t status bit %0d stuck", $time, b);
    end
  end
  endtask

  // One whole frame: command byte, then n data bytes from tx or into rx
  task automatic frame(input logic [7:0] cmd, input int n);
  begin
    reg_wr(HR_CMD, cmd);
    for (int i = 0; i < n; i++)
    begin
      wait_bit(HS_WAIT, 1'b1);
      reg_wr(HR_DATA, cmd[DIR_BIT] ? tx[i] : 8'h00);
      wait_bit(HS_PEND, 1'b0);
      if (!cmd[DIR_BIT])
      begin
        wait_bit(HS_RXV, 1'b1);
        reg_rd(HR_DATA, rx[i]);
      end
    end
    wait_bit(HS_WAIT, 1'b1);
    reg_wr(HR_END, 8'h00);
    wait_bit(HS_BUSY, 1'b0);
    chk(cmd_sh, cmd);
  end
  endtask

  task automatic end_of_test;
  begin
    $display("Comparisons %0d mismatches %0d", compares, err_count);
    if (err_count == 0 && compares > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  end
  endtask

  initial
  begin
    repeat (60000) @(posedge clk_sys);
    err_count = err_count + 1;
    $display("BAD t=%0t watchdog expired", $time);
    end_of_test();
  end

  initial
  begin
    clk_sys = 1'b0;
    arst_n = 1'b0;
    dev_clk_on = 1'b1;
    irq_in = 1'b0;
    reg_addr = 8'h00;
    reg_wdata = 8'h00;
    reg_we = 1'b0;
    reg_re = 1'b0;
    err_count = 0;
    compares = 0;
    repeat (12) @(posedge clk_sys);
    arst_n <= 1'b1;
    // Same traffic in four-pin, then three-pin mode
    for (int m = 0; m < 2; m++)
    begin
      mv = 8'(m);
      tx[0] = mv;
      frame(8'h80, 1);
      reg_wr(HR_CFG, mv);
      repeat (4) @(posedge clk_sys);
      chk(core_cfg, mv);
      chk({7'h00, i_rsp_if.three_pin}, mv);
      reg_rd(HR_CFG, rv);
      chk(rv, mv);
      tx[0] = 8'ha5 ^ mv;
      frame(8'h85, 1);
      frame(8'h05, 1);
      chk(rx[0], 8'ha5 ^ mv);
      for (int i = 0; i < 3; i++)
        tx[i] = 8'(8'h11 * (i + 1) + m);
      frame(8'hc8, 3);
      frame(8'h48, 3);
      for (int i = 0; i < 3; i++)
        chk(rx[i], tx[i]);
      frame(8'h08, 2);
      chk(rx[1], tx[0]);
      // Seventeen pushes into a sixteen deep file: the last one is lost
      for (int i = 0; i < 17; i++)
        tx[i] = 8'(i * 7 + m);
      frame(8'ha0, 17);
      frame(8'h01, 1);
      chk(rx[0], 8'h10);
      frame(8'h20, 16);
      for (int i = 0; i < 16; i++)
        chk(rx[i], tx[i]);
      frame(8'h01, 1);
      chk(rx[0], 8'h00);
      tx[0] = 8'h55;
      frame(8'h81, 1);
      frame(8'h01, 1);
      chk(rx[0], 8'h00);
    end
    tx[0] = 8'h00;
    frame(8'h80, 1);
    reg_wr(HR_CFG, 8'h00);
    // Device core clock stopped: the port must still work
    dev_clk_on <= 1'b0;
    tx[0] = 8'h3c;
    frame(8'h87, 1);
    frame(8'h07, 1);
    chk(rx[0], 8'h3c);
    dev_clk_on <= 1'b1;
    // Interrupt muxed onto the host data line while deselected
    tx[0] = 8'h02;
    frame(8'h80, 1);
    reg_wr(HR_CFG, 8'h02);
    repeat (8) @(posedge clk_sys);
    chk({7'h00, i_rsp_if.mosi_w}, 8'h00);
    irq_in <= 1'b1;
    repeat (8) @(posedge clk_sys);
    chk({7'h00, i_rsp_if.mosi_w}, 8'h01);
    chk({7'h00, i_rsp_if.irq_pin}, 8'h00);
    reg_rd(HR_STAT, rv);
    chk({7'h00, rv[HS_IRQ]}, 8'h01);
    tx[0] = 8'h5a;
    frame(8'h86, 1);
    frame(8'h06, 1);
    chk(rx[0], 8'h5a);
    tx[0] = 8'h00;
    frame(8'h80, 1);
    reg_wr(HR_CFG, 8'h00);
    repeat (8) @(posedge clk_sys);
    chk({7'h00, i_rsp_if.irq_pin}, 8'h01);
    reg_rd(HR_STAT, rv);
    chk({7'h00, rv[HS_IRQ]}, 8'h01);
    end_of_test();
  end
endmodule
`default_nettype wire
